// ---- rtl/rcs_pkg.sv ----
// Shared constants and helpers for the reset and clock-loss supervisor
package rcs_pkg;
    localparam int          ADDR_W         = 20;
    localparam int          DATA_W         = 32;
    // Register indices; the byte address is four times the index
    localparam logic [15:0] IDX_CLK_STAT   = 16'h009E;
    localparam logic [15:0] IDX_CLD        = 16'h6290;
    localparam logic [15:0] IDX_CLK_CMD    = 16'h00C6;
    localparam logic [15:0] IDX_RST_CTRL   = 16'h00C7;
    localparam logic [15:0] IDX_SLP_STAT   = 16'h00C8;
    // Clock command and status field layout
    localparam int          SRC32K_BIT     = 7;
    localparam int          SYSSRC_BIT     = 6;
    localparam int          TICK_LSB       = 3;
    localparam int          SPD_LSB        = 0;
    localparam int          CODE_W         = 3;
    localparam logic [7:0]  CMD_RESET      = 8'hC9;
    localparam logic [2:0]  CODE_RC_FLOOR  = 3'h1;
    // Control bits
    localparam int          CLD_EN_BIT     = 0;
    localparam int          FORCE_BIT      = 0;
    localparam int          WDT_EN_BIT     = 1;
    // Reset cause codes
    localparam logic [1:0]  CAUSE_POR      = 2'h0;
    localparam logic [1:0]  CAUSE_EXT      = 2'h1;
    localparam logic [1:0]  CAUSE_WDT      = 2'h2;
    localparam logic [1:0]  CAUSE_CLK      = 2'h3;
    localparam logic [15:0] PC_RESET       = 16'h0000;
    // Timing
    localparam real         CLK_PERIOD_NS  = 4.0;
    localparam real         NS_PER_MS      = 1.0e6;
    localparam real         LOSS_SLOW_MS   = 0.5;
    localparam real         LOSS_FAST_MS   = 0.25;
    localparam int          LOSS_SLOW_CYC  = $rtoi(LOSS_SLOW_MS * NS_PER_MS / CLK_PERIOD_NS);
    localparam int          LOSS_FAST_CYC  = $rtoi(LOSS_FAST_MS * NS_PER_MS / CLK_PERIOD_NS);
    localparam int          RESET_HOLD_CYC = 16;
    localparam int          HOLD_W         = 5;
    localparam int          LOSS_CNT_W     = 17;
    // AXI responses
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // Byte address of a register index
    function automatic logic [ADDR_W-1:0] rcs_byte_addr(input logic [15:0] idx);
        rcs_byte_addr = ADDR_W'({idx, 2'b00});
    endfunction : rcs_byte_addr

    // Raise a speed code to at least a floor (a larger code is slower)
    function automatic logic [2:0] rcs_clamp(input logic [2:0] code,
                                             input logic [2:0] floor_code);
        rcs_clamp = (code < floor_code) ? floor_code : code;
    endfunction : rcs_clamp
endpackage : rcs_pkg

// ---- rtl/rcs_loss_det.sv ----
// Clock-loss detector: watches two sampled oscillator levels for toggling
`timescale 1ns/1ns
module rcs_loss_det
    import rcs_pkg::*;
#(
    parameter int SLOW_LIM = LOSS_SLOW_CYC,
    parameter int FAST_LIM = LOSS_FAST_CYC,
    parameter int CNT_W    = LOSS_CNT_W
)(
    input  wire logic aclk,
    input  wire logic clear,
    input  wire logic ce,
    input  wire logic enable,
    input  wire logic halt,
    input  wire logic fast_lvl,
    input  wire logic slow_lvl,
    output logic      loss
);
    localparam logic [CNT_W-1:0] SLOW_MAX = CNT_W'(SLOW_LIM - 1);
    localparam logic [CNT_W-1:0] FAST_MAX = CNT_W'(FAST_LIM - 1);

    logic             run;
    logic             slow_d;
    logic             fast_d;
    logic [CNT_W-1:0] slow_cnt;
    logic [CNT_W-1:0] fast_cnt;

    // Low-power halt stops the watch; counts restart from zero afterwards
    assign run = enable && !halt;

    // Previous levels, for toggle detection
    always_ff @(posedge aclk)
    begin
        if (clear)
        begin
            slow_d <= 1'b0;
            fast_d <= 1'b0;
        end
        else if (ce)
        begin
            slow_d <= slow_lvl;
            fast_d <= fast_lvl;
        end
    end

    // RL11 mutual watch counters
    // RL17 halt clears counts
    always_ff @(posedge aclk)
    begin
        if (clear || (ce && !run))
        begin
            slow_cnt <= '0;
            fast_cnt <= '0;
        end
        else if (ce)
        begin
            slow_cnt <= (slow_lvl != slow_d) ? '0 :
                        (slow_cnt == SLOW_MAX) ? slow_cnt : slow_cnt + 1'b1;
            fast_cnt <= (fast_lvl != fast_d) ? '0 :
                        (fast_cnt == FAST_MAX) ? fast_cnt : fast_cnt + 1'b1;
        end
    end

    // RL12 slow clock timeout
    // RL13 fast clock timeout
    always_ff @(posedge aclk)
    begin
        if (clear)
            loss <= 1'b0;
        else if (ce)
            loss <= run && ((slow_cnt == SLOW_MAX) || (fast_cnt == FAST_MAX));
    end

    property p_slow_bound;
        @(posedge aclk) disable iff (clear) slow_cnt <= SLOW_MAX;
    endproperty
    a_slow_bound: assert property (p_slow_bound) // RL12
        else $error("slow-clock watch count passed its limit");

    property p_halt_idle;
        @(posedge aclk) disable iff (clear) ce && halt |=> !loss && slow_cnt == '0;
    endproperty
    a_halt_idle: assert property (p_halt_idle) // RL17
        else $error("detector kept running during low-power halt");

    property p_fast_loss;
        @(posedge aclk) disable iff (clear)
            ce && run && fast_cnt == FAST_MAX |=> loss;
    endproperty
    a_fast_loss: assert property (p_fast_loss) // RL13
        else $error("fast-clock loss not flagged at its limit");
endmodule : rcs_loss_det

// ---- rtl/rcs_supervisor.sv ----
// Reset supervisor with clock-loss detection, clock status and AXI4-Lite registers
`timescale 1ns/1ns
// Summary of operation
// RL1: System reset comes from pin, power-on, brownout, watchdog or clock loss.
// RL2: Processor start address presented on reset release is zero.
// RL3: Every reset returns all registers here and downstream to reset values.
// RL4: Watchdog enable and clock-loss detector enable are off after any reset.
// RL5: I/O pins are inputs with pull-ups, two designated pins without pulls.
// RL6: The reset pin always has its pull-up enabled.
// RL7: Writing one to the force bit starts a watchdog-type reset at once.
// RL8: Power-on and brownout keep reset held until both supplies are good.
// RL9: A brownout reset reports the same cause code as power-on.
// RL10: Software reads the two-bit reset cause in the sleep status register.
// RL11: Enabled detector watches both crystal clocks and resets if one stops.
// RL12: Stopped slow clock gives a clock-loss reset within 0.5 ms.
// RL13: Stopped fast clock gives a clock-loss reset within 0.25 ms.
// RL14: After reset both clocks run from the RC oscillators.
// RL15: Detector control bit 0 enables it, resets to 0, bits 7:1 read zero.
// RL16: Software keeps the crystal as system clock while the detector is used.
// RL17: Power modes one and two halt the detector, restarting it afterwards.
// RL18: Software disables the detector and uses RC before power mode three.
// RL19: Status bit 7 shows slow clock source, bit 6 system source; both reset 1.
// RL20: Status bits 5:3 show actual tick rate code; reset value 001.
// RL21: Status bits 2:0 show actual system clock speed code; reset value 001.
// RL22: Requested tick faster than the system clock is clamped to it.
// RL23: With RC system clock, requested code 000 reads back and acts as 001; here the command reads back 000, only the status shows 001.
// RL24: Cause codes follow a fixed priority and are latched at end of reset.
module rcs_supervisor
    import rcs_pkg::*;
#(
    parameter int         SLOW_LIM    = LOSS_SLOW_CYC,
    parameter int         FAST_LIM    = LOSS_FAST_CYC,
    parameter int         NUM_IO      = 8,
    parameter logic [7:0] NOPULL_MASK = 8'h03
)(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              clk_en,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              ext_reset_n,
    input  wire logic              por_ok,
    input  wire logic              bod_ok,
    input  wire logic              wdt_timeout,
    input  wire logic              low_power_halt,
    input  wire logic              crystal_oscillator_fast_lvl,
    input  wire logic              crystal_oscillator_slow_lvl,
    output logic                   sys_reset_n,
    output logic [15:0]            pc_start_addr,
    output logic                   wdt_enable,
    output logic                   sys_clk_sel_rc,
    output logic                   slow_clk_sel_rc,
    output logic [2:0]             tick_rate_code,
    output logic [2:0]             clk_rate_code,
    output logic [NUM_IO-1:0]      io_input_mode,
    output logic [NUM_IO-1:0]      io_pullup_en,
    output logic                   rst_pin_pullup_en
);
    typedef enum logic {ST_RUN, ST_HOLD} rcs_state_t;

    rcs_state_t        state;
    logic [HOLD_W-1:0] hold_cnt;
    logic [1:0]        pend_cause;
    logic [1:0]        reset_cause;
    logic              supply_bad;
    logic              src_hit;
    logic              sw_clear;
    logic              clk_loss;
    logic              force_req;
    logic [7:0]        clock_command_register;
    logic              cld_en;
    logic              stat_slow_clock_source_bit;
    logic              stat_osc;
    logic [2:0]        stat_tick;
    logic [2:0]        stat_spd;
    logic [2:0]        next_spd;
    logic [ADDR_W-1:0] aw_addr;
    logic              aw_full;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              w_full;
    logic              wr_go;
    logic              rd_go;
    logic              rd_is_cld;
    logic [31:0]       rd_word;
    logic              rd_hit;
    logic              wr_hit;

    // RL8 supply hold
    assign supply_bad = !por_ok || !bod_ok;
    // RL1 five reset sources
    assign src_hit    = supply_bad || !ext_reset_n || wdt_timeout || force_req || clk_loss;
    // RL3 clear while held
    assign sw_clear   = !aresetn || (state == ST_HOLD);

    // Reset sequencer: hold while a supply or pin fault stands, then stretch a fixed time
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state    <= ST_HOLD;
            hold_cnt <= '0;
        end
        else if (clk_en)
        begin
            case (state)
                ST_RUN:
                begin
                    hold_cnt <= '0;
                    if (src_hit)
                        state <= ST_HOLD;
                end
                ST_HOLD:
                begin
                    if (supply_bad || !ext_reset_n)
                        hold_cnt <= '0;
                    else if (hold_cnt == HOLD_W'(RESET_HOLD_CYC - 1))
                        state <= ST_RUN;
                    else
                        hold_cnt <= hold_cnt + 1'b1;
                end
                default:
                    state <= ST_HOLD;
            endcase
        end
    end

    // RL9 brownout as power-on
    // RL24 cause priority
    // Power-on wins over every other cause seen during the same hold
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pend_cause <= CAUSE_POR;
        else if (clk_en)
        begin
            if (supply_bad)
                pend_cause <= CAUSE_POR;
            else if (state == ST_RUN && src_hit)
                pend_cause <= !ext_reset_n ? CAUSE_EXT :
                              clk_loss     ? CAUSE_CLK : CAUSE_WDT;
        end
    end

    // RL24 latch at release
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            reset_cause <= CAUSE_POR;
        else if (clk_en && state == ST_HOLD && !supply_bad && ext_reset_n
                 && hold_cnt == HOLD_W'(RESET_HOLD_CYC - 1))
            reset_cause <= pend_cause;
    end

    // Registered reset output keeps glitches off the system reset net
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            sys_reset_n <= 1'b0;
        else if (clk_en)
            sys_reset_n <= (state == ST_RUN) && !src_hit;
    end

    // RL2 start address
    assign pc_start_addr     = PC_RESET;
    // RL5 pin defaults
    assign io_input_mode     = '1;
    assign io_pullup_en      = ~NOPULL_MASK[NUM_IO-1:0];
    // RL6 reset pin pull-up
    assign rst_pin_pullup_en = 1'b1;

    rcs_loss_det #(
        .SLOW_LIM (SLOW_LIM),
        .FAST_LIM (FAST_LIM),
        .CNT_W    (LOSS_CNT_W)
    ) u_loss (
        .aclk     (aclk),
        .clear    (sw_clear),
        .ce       (clk_en),
        .enable   (cld_en),
        .halt     (low_power_halt),
        .fast_lvl (crystal_oscillator_fast_lvl),
        .slow_lvl (crystal_oscillator_slow_lvl),
        .loss     (clk_loss)
    );

    // Write channel capture; address and data may arrive in either order
    assign s_axi_awready = clk_en && !aw_full;
    assign s_axi_wready  = clk_en && !w_full;
    assign wr_go         = clk_en && aw_full && w_full && !s_axi_bvalid;
    assign wr_hit        = (aw_addr == rcs_byte_addr(IDX_CLK_CMD))
                        || (aw_addr == rcs_byte_addr(IDX_CLD))
                        || (aw_addr == rcs_byte_addr(IDX_RST_CTRL))
                        || (aw_addr == rcs_byte_addr(IDX_CLK_STAT))
                        || (aw_addr == rcs_byte_addr(IDX_SLP_STAT));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full <= 1'b0;
            w_full  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
        end
        else if (clk_en)
        begin
            if (s_axi_awvalid && !aw_full)
            begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (wr_go)
                aw_full <= 1'b0;
            if (s_axi_wvalid && !w_full)
            begin
                w_full <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (wr_go)
                w_full <= 1'b0;
        end
    end

    // Write response, one cycle after both halves are held
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // RL7 force reset
    // A single-cycle request; the bit itself reads back as zero
    assign force_req = wr_go && w_strb[0] && w_data[FORCE_BIT]
                    && aw_addr == rcs_byte_addr(IDX_RST_CTRL);

    // RL4 disabled after reset
    // RL15 detector enable bit
    always_ff @(posedge aclk)
    begin
        if (sw_clear)
        begin
            cld_en     <= 1'b0;
            wdt_enable <= 1'b0;
        end
        else if (clk_en && wr_go && w_strb[0])
        begin
            if (aw_addr == rcs_byte_addr(IDX_CLD))
                cld_en <= w_data[CLD_EN_BIT];
            if (aw_addr == rcs_byte_addr(IDX_RST_CTRL))
                wdt_enable <= w_data[WDT_EN_BIT];
        end
    end

    // Clock command: any value is accepted, the status shows what is applied
    always_ff @(posedge aclk)
    begin
        if (sw_clear)
            clock_command_register <= CMD_RESET;
        else if (clk_en && wr_go && w_strb[0] && aw_addr == rcs_byte_addr(IDX_CLK_CMD))
            clock_command_register <= w_data[7:0];
    end

    // RL23 RC speed floor
    assign next_spd = clock_command_register[SYSSRC_BIT]
                    ? rcs_clamp(clock_command_register[SPD_LSB +: CODE_W], CODE_RC_FLOOR)
                    : clock_command_register[SPD_LSB +: CODE_W];

    // RL14 RC after reset
    // RL19 source status
    // RL20 tick status
    // RL21 speed status
    // RL22 tick clamp
    always_ff @(posedge aclk)
    begin
        if (sw_clear)
        begin
            stat_slow_clock_source_bit <= CMD_RESET[SRC32K_BIT];
            stat_osc    <= CMD_RESET[SYSSRC_BIT];
            stat_tick   <= CMD_RESET[TICK_LSB +: CODE_W];
            stat_spd    <= CMD_RESET[SPD_LSB +: CODE_W];
        end
        else if (clk_en)
        begin
            stat_slow_clock_source_bit <= clock_command_register[SRC32K_BIT];
            stat_osc    <= clock_command_register[SYSSRC_BIT];
            stat_spd    <= next_spd;
            stat_tick   <= rcs_clamp(clock_command_register[TICK_LSB +: CODE_W], next_spd);
        end
    end

    assign sys_clk_sel_rc  = stat_osc;
    assign slow_clk_sel_rc = stat_slow_clock_source_bit;
    assign tick_rate_code  = stat_tick;
    assign clk_rate_code   = stat_spd;

    // Read decode; reserved bits of every register read zero
    // RL10 cause readback
    always_comb
    begin
        rd_word = '0;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            rcs_byte_addr(IDX_CLK_STAT):
                rd_word[7:0] = {stat_slow_clock_source_bit, stat_osc, stat_tick, stat_spd};
            rcs_byte_addr(IDX_CLK_CMD):
                rd_word[7:0] = clock_command_register;
            rcs_byte_addr(IDX_CLD):
                rd_word[CLD_EN_BIT] = cld_en;
            rcs_byte_addr(IDX_RST_CTRL):
                rd_word[WDT_EN_BIT] = wdt_enable;
            rcs_byte_addr(IDX_SLP_STAT):
                rd_word[1:0] = reset_cause;
            default:
                rd_hit = 1'b0;
        endcase
    end

    assign s_axi_arready = clk_en && !s_axi_rvalid;
    assign rd_go         = s_axi_arvalid && s_axi_arready;

    // Read data held in a register until the master takes it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
            rd_is_cld    <= 1'b0;
        end
        else if (clk_en)
        begin
            if (rd_go)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
                rd_is_cld    <= s_axi_araddr == rcs_byte_addr(IDX_CLD);
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    property p_ext_reset;
        @(posedge aclk) disable iff (!aresetn) clk_en && !ext_reset_n |=> !sys_reset_n;
    endproperty
    a_ext_reset: assert property (p_ext_reset) // RL1
        else $error("pin reset did not drop system reset");

    property p_force;
        @(posedge aclk) disable iff (!aresetn)
            clk_en && force_req |=> state == ST_HOLD && pend_cause == CAUSE_WDT;
    endproperty
    a_force: assert property (p_force) // RL7
        else $error("force write did not start a watchdog reset");

    property p_release_off;
        @(posedge aclk) disable iff (!aresetn)
            $rose(sys_reset_n) |-> !cld_en && !wdt_enable && pc_start_addr == PC_RESET;
    endproperty
    a_release_off: assert property (p_release_off) // RL4
        else $error("enable bits set at reset release");

    property p_supply;
        @(posedge aclk) disable iff (!aresetn)
            clk_en && supply_bad |=> pend_cause == CAUSE_POR && !sys_reset_n;
    endproperty
    a_supply: assert property (p_supply) // RL9
        else $error("supply fault not held as power-on");

    property p_cld_read;
        @(posedge aclk) disable iff (!aresetn)
            s_axi_rvalid && rd_is_cld |-> s_axi_rdata[31:1] == 31'h0;
    endproperty
    a_cld_read: assert property (p_cld_read) // RL15
        else $error("reserved detector bits read nonzero");

    property p_rc_floor;
        @(posedge aclk) disable iff (!aresetn) stat_osc |-> stat_spd != 3'h0;
    endproperty
    a_rc_floor: assert property (p_rc_floor) // RL23
        else $error("RC clock reports 32 MHz speed");

    property p_tick_clamp;
        @(posedge aclk) disable iff (!aresetn) stat_tick >= stat_spd;
    endproperty
    a_tick_clamp: assert property (p_tick_clamp) // RL22
        else $error("tick rate above system clock");

    property p_loss_reset;
        @(posedge aclk) disable iff (!aresetn)
            clk_en && clk_loss && state == ST_RUN |=> pend_cause == CAUSE_CLK || !por_ok
                || !bod_ok || !ext_reset_n;
    endproperty
    a_loss_reset: assert property (p_loss_reset) // RL11
        else $error("clock loss not recorded as cause");

    c_loss: cover property (@(posedge aclk) disable iff (!aresetn) clk_loss);
    c_force: cover property (@(posedge aclk) disable iff (!aresetn) force_req);
    c_rc_clamp: cover property (@(posedge aclk) disable iff (!aresetn)
        stat_osc && stat_spd == CODE_RC_FLOOR && stat_tick == CODE_RC_FLOOR);
    c_release: cover property (@(posedge aclk) disable iff (!aresetn) $rose(sys_reset_n));
endmodule : rcs_supervisor

// ---- bench/rcs_xtal_model.sv ----
// Crystal clock level model for the far side of the supervisor
`timescale 1ns/1ns
module rcs_xtal_model (
    input  wire logic aclk,
    input  wire logic fast_stop,
    input  wire logic slow_stop,
    output logic      fast_lvl,
    output logic      slow_lvl
);
    logic [2:0] div = 3'h0;
    initial {fast_lvl, slow_lvl} = 2'h0;
    // A dead crystal freezes its level; the slow one toggles every eighth cycle
    always @(posedge aclk)
    begin
        div <= div + 3'h1;
        if (!fast_stop)
            fast_lvl <= !fast_lvl;
        if (!slow_stop && div == 3'h7)
            slow_lvl <= !slow_lvl;
    end
endmodule : rcs_xtal_model

// ---- bench/rcs_supervisor_tb.sv ----
// Self-checking bench for the reset and clock-loss supervisor
`timescale 1ns/1ns
module rcs_supervisor_tb;
    localparam logic [19:0] A_ST = 20'h00278, A_CLD = 20'h18A40, A_CMD = 20'h00318;
    localparam logic [19:0] A_RC = 20'h0031C, A_SS = 20'h00320;
    logic aclk = 0, aresetn = 0, pin_n = 1, brownout_detector = 1, wdt = 0, halt = 0, fs = 0, ss = 0;
    logic awvalid = 0, wvalid = 0, arvalid = 0, bready = 0, rready = 0, fl, sl, srn, wen;
    logic awready, wready, arready, bvalid, rvalid, pull;
    logic [19:0] addr = 20'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  bresp, rresp;
    logic [15:0] pc;
    logic [7:0]  iom, iop, cs;
    int fail_count = 0, checks_done = 0;
    // Short loss limits keep each clock-loss run to a few dozen cycles
    rcs_supervisor #(.SLOW_LIM(40), .FAST_LIM(20)) u_dut (.aclk, .aresetn, .clk_en(1'b1),
        .s_axi_awaddr(addr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(addr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_reset_n(pin_n), .por_ok(1'b1), .bod_ok(brownout_detector), .wdt_timeout(wdt),
        .low_power_halt(halt), .crystal_oscillator_fast_lvl(fl), .crystal_oscillator_slow_lvl(sl), .sys_reset_n(srn),
        .pc_start_addr(pc), .wdt_enable(wen), .sys_clk_sel_rc(cs[6]), .slow_clk_sel_rc(cs[7]),
        .tick_rate_code(cs[5:3]), .clk_rate_code(cs[2:0]), .io_input_mode(iom),
        .io_pullup_en(iop), .rst_pin_pullup_en(pull));
    rcs_xtal_model u_xtal (.aclk, .fast_stop(fs), .slow_stop(ss), .fast_lvl(fl), .slow_lvl(sl));
    always #2 aclk = !aclk;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    // One bus transfer; each valid drops only after the edge that took it
    task automatic bus(input logic w, input logic [19:0] a, input logic [31:0] d,
                       input logic [1:0] er);
        int n;
        logic ta, tw, tr, dn;
        logic [33:0] v;
        n = 0;
        addr <= a;
        wdata <= d;
        awvalid <= w;
        wvalid <= w;
        bready <= w;
        arvalid <= !w;
        rready <= !w;
        do
        begin
            @(negedge aclk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tr = arvalid & arready;
            dn = w ? bvalid : rvalid;
            v = w ? {bresp, 32'h0} : {rresp, rdata};
            @(posedge aclk);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
            if (tr)
                arvalid <= 1'b0;
            n++;
        end while (!dn && n < 64);
        bready <= 1'b0;
        rready <= 1'b0;
        // A spent wait limit counts as a mismatch
        chk(dn, 1'b1);
        chk(v[33:32], er);
        if (!w)
            chk(v[31:0], d);
        // Let an edge pass so the next call never re-drives a strobe in this step
        @(posedge aclk);
    endtask : bus
    // Bounded wait for the system reset output to reach a level
    task automatic wsys(input logic lv, input int lim);
        int n;
        n = 0;
        do
        begin
            @(negedge aclk);
            n++;
        end while (srn !== lv && n < lim);
        chk(srn, lv);
        @(posedge aclk);
    endtask : wsys
    task automatic close_out();
        if (fail_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    // The sequence needs about four hundred cycles; twenty-five times that means a hang
    initial
    begin
        #40000;
        fail_count++;
        close_out();
    end
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        wsys(1'b1, 40);
        chk({pc, iom, iop}, 32'h0000FFFC);
        chk(pull, 1'b1);
        chk(cs, 32'hC9);
        bus(0, A_ST, 32'hC9, 2'h0);
        bus(0, A_SS, 32'h0, 2'h0);
        bus(0, 20'h00004, 32'h0, 2'h2);
        bus(1, A_CMD, 32'h82, 2'h0);
        bus(0, A_ST, 32'h92, 2'h0);
        chk(cs, 32'h92);
        bus(1, A_CMD, 32'hC0, 2'h0);
        bus(0, A_ST, 32'hC9, 2'h0);
        bus(1, A_CMD, 32'h80, 2'h0);
        bus(1, A_CLD, 32'hFFFFFFFF, 2'h0);
        bus(0, A_CLD, 32'h1, 2'h0);
        ss <= 1'b1;
        wsys(1'b0, 46);
        ss <= 1'b0;
        wsys(1'b1, 40);
        bus(0, A_SS, 32'h3, 2'h0);
        bus(0, A_CLD, 32'h0, 2'h0);
        bus(0, A_ST, 32'hC9, 2'h0);
        bus(1, A_CLD, 32'h1, 2'h0);
        halt <= 1'b1;
        fs <= 1'b1;
        repeat (60) @(posedge aclk);
        wsys(1'b1, 1);
        halt <= 1'b0;
        wsys(1'b0, 26);
        fs <= 1'b0;
        wsys(1'b1, 40);
        bus(1, A_RC, 32'h2, 2'h0);
        chk(wen, 1'b1);
        bus(1, A_RC, 32'h1, 2'h0);
        wsys(1'b0, 4);
        chk(wen, 1'b0);
        wsys(1'b1, 40);
        bus(0, A_SS, 32'h2, 2'h0);
        // Pin, brownout and watchdog in turn; brownout must read as power-on
        for (int i = 0; i < 3; i++)
        begin
            pin_n <= (i != 0);
            brownout_detector <= (i != 1);
            wdt <= (i == 2);
            wsys(1'b0, 4);
            {pin_n, brownout_detector, wdt} <= 3'b110;
            wsys(1'b1, 40);
            bus(0, A_SS, (i == 0) ? 32'h1 : 32'(2 * i - 2), 2'h0);
        end
        // Deep-sleep entry: RC system clock first, then the detector off
        bus(1, A_CLD, 32'h1, 2'h0);
        bus(1, A_CMD, 32'hC9, 2'h0);
        bus(1, A_CLD, 32'h0, 2'h0);
        bus(0, A_CLD, 32'h0, 2'h0);
        close_out();
    end
endmodule : rcs_supervisor_tb
